/* File: dv/remote_terminal.sv */
// Remote terminal model that drives the receive line
`timescale 1ns/1ps
module remote_terminal (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_active,
    // Line
    output logic o_line
);
    logic [7:0] pat;
    // Idle line rests at mark level; active line follows a pseudo-random pattern shifted every cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pat <= 8'h5c;
            o_line <= 1'b1;
        end else begin
            pat <= {pat[6:0], pat[7] ^ pat[5]};
            o_line <= i_active ? pat[0] : 1'b1;
        end
    end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench of the serial port control block
`timescale 1ns/1ps
`include "spc_consts.svh"
module testbench;
    import spc_pkg::*;
    // ==========================================================
    // Signals
    logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, act = 1'b0;
    logic emp = 1'b0, txs = 1'b1;
    logic [3:0] hist;
    logic [7:0] i_addr = 8'h00;
    word_t i_wdata = 32'h0, rd_v, seed = 32'h000161a0, o_rdata, o_line_cfg;
    logic [8:0] ev = 9'h000;
    logic [8:0] o_tx_data;
    logic [3:0] o_char_bits;
    logic [1:0] o_stop_halves;
    logic [4:0] o_oversample;
    logic rxd, o_txd, o_sck_oe, o_dtr_n, o_rts_n, o_rx_reset, o_tx_reset, o_rx_enable;
    logic o_tx_enable, o_timeout_hold, o_timeout_restart, o_tx_load, o_tx_addr_bit;
    logic o_nak_send, o_rx_line, o_msb_first, o_smart_card;
    logic [3:0] ctl;
    int mismatches = 0, checks = 0, cyc = 0, naks = 0, n0, lows = 0, highs = 0;
    int pos[4] = '{4, 6, 16, 18};
    int mode_m;
    assign ctl = {o_rts_n, o_dtr_n, o_tx_enable, o_rx_enable};
    serial_port_command_and_line_config i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_thr_empty(emp), .i_tsr_empty(emp), .i_bit_tick(ev[7]), .i_sample_tick(ev[8]),
        .i_char_rx(ev[0]), .i_parity_err(ev[1]), .i_frame_err(ev[2]), .i_overrun(ev[3]),
        .i_break_seen(ev[4]), .i_timeout_expire(ev[5]), .i_nak_seen(ev[6]),
        .i_tx_serial(txs), .i_rxd(rxd), .o_txd(o_txd), .o_sck_oe(o_sck_oe),
        .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n), .o_rx_reset(o_rx_reset),
        .o_tx_reset(o_tx_reset), .o_rx_enable(o_rx_enable), .o_tx_enable(o_tx_enable),
        .o_timeout_hold(o_timeout_hold), .o_timeout_restart(o_timeout_restart),
        .o_tx_load(o_tx_load), .o_tx_data(o_tx_data), .o_tx_addr_bit(o_tx_addr_bit),
        .o_nak_send(o_nak_send), .o_rx_line(o_rx_line), .o_line_cfg(o_line_cfg),
        .o_char_bits(o_char_bits), .o_stop_halves(o_stop_halves),
        .o_oversample(o_oversample), .o_msb_first(o_msb_first), .o_smart_card(o_smart_card));
    remote_terminal i_far (.i_clk(i_clk), .i_resetn(i_resetn), .i_active(act), .o_line(rxd));
    // ==========================================================
    // Clock, watchdog and helpers
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        naks += (o_nak_send === 1'b1);
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    function automatic word_t lfsr(input word_t s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input word_t d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output word_t d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic pulse(input int b);
        @(posedge i_clk);
        ev[b] <= 1'b1;
        @(posedge i_clk);
        ev <= 9'h000;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        #1;
        chk({o_dtr_n, o_rts_n, o_txd, o_char_bits, o_oversample}, {3'h7, 4'h5, 5'h10});
        wr(`CMD_OFF, 32'h4);
        chk({o_rx_reset, o_tx_reset}, 2'h2);
        wr(`CMD_OFF, 32'h8);
        chk({o_rx_reset, o_tx_reset}, 2'h1);
        for (int k = 0; k < 4; k++) begin
            wr(`CMD_OFF, 32'h1 << pos[k]);
            chk(ctl[k], k < 2);
            wr(`CMD_OFF, 32'h3 << pos[k]);
            chk(ctl[k], k >= 2);
        end
        $display("test commands done");
        for (int n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            mode_m = seed & `MODE_MASK;
            wr(`MODE_OFF, seed);
            rd(`MODE_OFF, rd_v);
            chk(rd_v, mode_m);
            chk(o_line_cfg, mode_m);
            chk({o_msb_first, o_char_bits}, {mode_m[16], mode_m[17] ? 4'h9 : 4'h5 + mode_m[7:6]});
            chk(o_oversample, mode_m[19] ? 5'h08 : 5'h10);
            chk(o_smart_card, mode_m[3:0] == 4 || mode_m[3:0] == 6);
            chk(o_sck_oe, mode_m[18] && mode_m[5:4] != 2'h3);
            chk(o_stop_halves, mode_m[13:12] == 0 ? 2 : (mode_m[13:12] == 1 && !mode_m[8]) ? 3 : 0);
        end
        $display("test line config done");
        wr(`IER_OFF, 32'hffffffff);
        wr(`IDR_OFF, 32'h5);
        rd(`IMR_OFF, rd_v);
        chk(rd_v, `IRQ_MASK & ~32'h5);
        rd(8'h2c, rd_v);
        chk(rd_v, 32'h0);
        pulse(1);
        pulse(2);
        pulse(3);
        pulse(4);
        rd(`CSR_OFF, rd_v);
        chk(rd_v & 32'he4, 32'he4);
        wr(`CMD_OFF, 32'h100);
        rd(`CSR_OFF, rd_v);
        chk(rd_v & 32'he4, 32'h0);
        pulse(5);
        rd(`CSR_OFF, rd_v);
        chk(rd_v[8], 1'b1);
        wr(`CMD_OFF, 32'h8800);
        chk({o_timeout_hold, o_timeout_restart}, 2'h3);
        rd(`CSR_OFF, rd_v);
        chk(rd_v[8], 1'b0);
        pulse(0);
        chk(o_timeout_hold, 1'b0);
        $display("test status done");
        wr(`MODE_OFF, 32'hc00);
        wr(`CMD_OFF, 32'h1000);
        wr(`THR_OFF, 32'h1a5);
        chk({o_tx_load, o_tx_addr_bit, o_tx_data}, 11'h7a5);
        wr(`THR_OFF, 32'h0a5);
        chk({o_tx_load, o_tx_addr_bit, o_tx_data}, 11'h4a5);
        wr(`MODE_OFF, 32'h4);
        n0 = naks;
        pulse(1);
        chk(naks - n0, 1);
        wr(`MODE_OFF, 32'h100004);
        pulse(1);
        chk(naks - n0, 1);
        wr(`MODE_OFF, 32'h01200004);
        wr(`CMD_OFF, 32'h2000);
        n0 = naks;
        pulse(1);
        pulse(1);
        chk(naks - n0, 1);
        wr(`MODE_OFF, 32'h0);
        wr(`CMD_OFF, 32'h2200);
        rd(`CSR_OFF, rd_v);
        chk(rd_v[10], 1'b1);
        $display("test transmit and nak done");
        chk(o_txd, 1'b1);
        @(posedge i_clk);
        emp <= 1'b1;
        wr(`CMD_OFF, 32'h400);
        chk(o_txd, 1'b0);
        @(posedge i_clk);
        ev[7] <= 1'b1;
        txs <= 1'b0;
        repeat (30) begin
            @(posedge i_clk);
            #1;
            if (o_txd) begin
                highs++;
            end else if (highs == 0) begin
                lows++;
            end
        end
        chk(lows >= 8, 1'b1);
        chk(highs, 12);
        $display("test break done");
        wr(`MODE_OFF, 32'h10004000);
        @(posedge i_clk);
        act <= 1'b1;
        ev <= 9'h100;
        hist = 4'hf;
        for (int n = 0; n < 12; n++) begin
            @(posedge i_clk);
            #1;
            chk(o_txd, hist[0]);
            chk(o_rx_line, hist[1] + hist[2] + hist[3] > 1);
            hist = {hist[2:0], rxd};
        end
        $display("test echo and filter done");
        finish_test();
    end
endmodule

/* File: hw/rx_filt_if.sv */
// Receive line filter connection
`timescale 1ns/1ps
interface rx_filt_if;
    logic raw;
    logic tick;
    logic en;
    logic clean;
    modport ctl (output raw, output tick, output en, input clean);
    modport filt (input raw, input tick, input en, output clean);
endinterface

/* File: hw/rx_maj_filter.sv */
// Three-sample majority filter for the receive line
`timescale 1ns/1ps
module rx_maj_filter (
    input wire logic i_clk,
    input wire logic i_resetn,
    rx_filt_if.filt f
);
    logic [2:0] samp;
    logic maj;

    assign maj = (samp[0] & samp[1]) | (samp[1] & samp[2]) | (samp[0] & samp[2]);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            samp <= 3'h7;
        end else if (f.tick) begin
            samp <= {samp[1:0], f.raw};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            f.clean <= 1'b1;
        end else begin
            f.clean <= f.en ? maj : f.raw;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    filt_vote_a: assert property (f.en && samp == 3'h3 |=> f.clean)
        else $error("filter vote wrong");
endmodule

/* File: hw/serial_port_command_and_line_config.sv */
// Command decode and line configuration of the serial port
//
// How it works
// - Reset command bits pulse receiver/transmitter reset
// - Receiver on unless off set; off wins
// - Transmitter on unless off set; off wins
// - Error clear drops parity, frame, overrun, break
// - Break starts after holding and shift empty
// - Break ends on end command once one character has passed, then 12 marks
// - Timer arm clears flag, holds until character
// - Multidrop address command marks next character
// - Retry clear in smart card; nak clear
// - Terminal ready assert low, deassert high
// - Send request assert low, deassert high
// - Four-bit operating mode field selects mode
// - Clock source select; clock drive when internal
// - Character length 5 to 8, or nine
// - Sync select and 16x or 8x sampling
// - Parity field selects parity kind
// - Stop bit count 1, 1.5, 2
// - Loop field selects echo or loopbacks
// - Bit order select LSB or MSB first
// - Smart card nak on parity error unless inhibited
// - Count repeated naks to limit, then flag
// - Infrared filter is 2 of 3 vote
// - Interrupt enable writes set mask bits
`timescale 1ns/1ps
`include "spc_consts.svh"
module serial_port_command_and_line_config
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Shift engine events
    input wire logic i_thr_empty,
    input wire logic i_tsr_empty,
    input wire logic i_bit_tick,
    input wire logic i_sample_tick,
    input wire logic i_char_rx,
    input wire logic i_parity_err,
    input wire logic i_frame_err,
    input wire logic i_overrun,
    input wire logic i_break_seen,
    input wire logic i_timeout_expire,
    input wire logic i_nak_seen,
    input wire logic i_tx_serial,
    // Serial pins
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_sck_oe,
    output logic o_dtr_n,
    output logic o_rts_n,
    // Engine control
    output logic o_rx_reset,
    output logic o_tx_reset,
    output logic o_rx_enable,
    output logic o_tx_enable,
    output logic o_timeout_hold,
    output logic o_timeout_restart,
    output logic o_tx_load,
    output logic [8:0] o_tx_data,
    output logic o_tx_addr_bit,
    output logic o_nak_send,
    output logic o_rx_line,
    // Line configuration
    output logic [31:0] o_line_cfg,
    output logic [3:0] o_char_bits,
    output logic [1:0] o_stop_halves,
    output logic [4:0] o_oversample,
    output logic o_msb_first,
    output logic o_smart_card
);
    // ==========================================================
    // Decode helpers
    function automatic logic [3:0] data_bits(input word_t c);
        return c[`F_NINE] ? 4'h9 : 4'h5 + {2'h0, c[`F_CHAR_LENGTH_LO +: 2]};
    endfunction

    function automatic logic [3:0] frame_bits(input word_t c);
        logic [3:0] n;
        n = data_bits(c) + 4'h2;
        if (c[`F_PAR_LO + 1 +: 2] != 2'h2) begin
            n = n + 4'h1;
        end
        if (c[`F_STOP_LO +: 2] == 2'h2) begin
            n = n + 4'h1;
        end
        return n;
    endfunction

    function automatic logic is_smart(input word_t c);
        return c[`F_MODE_LO +: 4] == `MD_ISO_T0 || c[`F_MODE_LO +: 4] == `MD_ISO_T1;
    endfunction

    // ==========================================================
    // Write strobes
    word_t cfg;
    logic cmd_wr;
    logic [31:0] cw;
    logic smart;
    logic multidrop;
    logic [1:0] loop;

    assign cmd_wr = i_wr && i_addr == `CMD_OFF;
    assign cw = cmd_wr ? i_wdata : 32'h0;
    assign smart = is_smart(cfg);
    assign multidrop = cfg[`F_PAR_LO + 1 +: 2] == 2'h3;
    assign loop = cfg[`F_LOOP_LO +: 2];

    // ==========================================================
    // Line configuration register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg <= `MODE_RESET;
        end else if (i_wr && i_addr == `MODE_OFF) begin
            cfg <= i_wdata & `MODE_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_line_cfg <= `MODE_RESET;
            o_char_bits <= 4'h5;
            o_stop_halves <= 2'h2;
            o_oversample <= `OVS_16;
            o_msb_first <= 1'b0;
            o_smart_card <= 1'b0;
            o_sck_oe <= 1'b0;
        end else begin
            o_line_cfg <= cfg;
            o_char_bits <= data_bits(cfg);
            case (cfg[`F_STOP_LO +: 2])
                2'h0: o_stop_halves <= 2'h2;
                2'h1: o_stop_halves <= cfg[`F_SYNC] ? 2'h0 : 2'h3;
                2'h2: o_stop_halves <= 2'h0;
                default: o_stop_halves <= 2'h0;
            endcase
            o_oversample <= cfg[`F_OVER] ? `OVS_8 : `OVS_16;
            o_msb_first <= cfg[`F_BIT_ORDER_SELECT];
            o_smart_card <= smart;
            o_sck_oe <= cfg[`F_SERIAL_CLOCK_DRIVE] && cfg[`F_CLKS_LO +: 2] != `CLKS_EXT;
        end
    end

    // ==========================================================
    // Receiver and transmitter control
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_reset <= 1'b0;
            o_tx_reset <= 1'b0;
        end else begin
            o_rx_reset <= cw[`C_RX_RST];
            o_tx_reset <= cw[`C_TX_RST];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_enable <= 1'b0;
        end else if (cw[`C_RX_OFF]) begin
            o_rx_enable <= 1'b0;
        end else if (cw[`C_RX_ON]) begin
            o_rx_enable <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_enable <= 1'b0;
        end else if (cw[`C_TX_OFF]) begin
            o_tx_enable <= 1'b0;
        end else if (cw[`C_TX_ON]) begin
            o_tx_enable <= 1'b1;
        end
    end

    // ==========================================================
    // Modem lines
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dtr_n <= 1'b1;
            o_rts_n <= 1'b1;
        end else begin
            if (cw[`C_TR_DEASSERT]) begin
                o_dtr_n <= 1'b1;
            end else if (cw[`C_TR_ASSERT]) begin
                o_dtr_n <= 1'b0;
            end
            if (cw[`C_SR_DEASSERT]) begin
                o_rts_n <= 1'b1;
            end else if (cw[`C_SR_ASSERT]) begin
                o_rts_n <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Status flags, set wins over clear
    logic f_par, f_frame, f_ovr, f_brk, f_tout, f_iter, f_nak;
    logic iter_clr;

    assign iter_clr = cw[`C_RETRY_CLR] && smart;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            f_par <= 1'b0;
            f_frame <= 1'b0;
            f_ovr <= 1'b0;
            f_brk <= 1'b0;
        end else begin
            f_par <= i_parity_err | (f_par & ~cw[`C_ERR_CLR]);
            f_frame <= i_frame_err | (f_frame & ~cw[`C_ERR_CLR]);
            f_ovr <= i_overrun | (f_ovr & ~cw[`C_ERR_CLR]);
            f_brk <= i_break_seen | (f_brk & ~cw[`C_ERR_CLR]);
        end
    end

    // ==========================================================
    // Idle timer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            f_tout <= 1'b0;
            o_timeout_hold <= 1'b0;
            o_timeout_restart <= 1'b0;
        end else begin
            f_tout <= i_timeout_expire | (f_tout & ~cw[`C_TO_ARM]);
            if (i_char_rx) begin
                o_timeout_hold <= 1'b0;
            end else if (cw[`C_TO_ARM]) begin
                o_timeout_hold <= 1'b1;
            end
            o_timeout_restart <= cw[`C_TO_RESTART];
        end
    end

    // ==========================================================
    // Smart card negative acknowledge
    logic [2:0] iter_cnt;
    logic at_limit;
    logic bad_char;

    assign at_limit = iter_cnt == cfg[`F_ITER_LO +: 3];
    assign bad_char = smart && i_parity_err;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            iter_cnt <= 3'h0;
        end else if (o_rx_reset || (i_char_rx && !i_parity_err)) begin
            iter_cnt <= 3'h0;
        end else if (bad_char && cfg[`F_REPEAT_NAK_DISABLE] && !at_limit) begin
            iter_cnt <= iter_cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_nak_send <= 1'b0;
            f_iter <= 1'b0;
            f_nak <= 1'b0;
        end else begin
            o_nak_send <= bad_char && !cfg[`F_NAK_INHIBIT] &&
                (!cfg[`F_REPEAT_NAK_DISABLE] || !at_limit);
            f_iter <= (bad_char && cfg[`F_REPEAT_NAK_DISABLE] && at_limit) |
                (f_iter & ~iter_clr);
            f_nak <= i_nak_seen | (f_nak & ~cw[`C_NAK_CLR]);
        end
    end

    // ==========================================================
    // Transmit holding write and address marking
    logic addr_pend;
    logic thr_wr;

    assign thr_wr = i_wr && i_addr == `THR_OFF;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_pend <= 1'b0;
        end else if (o_tx_reset || thr_wr) begin
            addr_pend <= 1'b0;
        end else if (cw[`C_ADDR] && multidrop) begin
            addr_pend <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_load <= 1'b0;
            o_tx_data <= 9'h0;
            o_tx_addr_bit <= 1'b0;
        end else begin
            o_tx_load <= thr_wr;
            if (thr_wr) begin
                o_tx_data <= i_wdata[8:0];
                o_tx_addr_bit <= addr_pend && multidrop;
            end
        end
    end

    // ==========================================================
    // Break sequencer
    brk_e brk_st;
    logic [3:0] brk_cnt;
    logic brk_stop;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            brk_st <= BRK_IDLE;
            brk_cnt <= 4'h0;
            brk_stop <= 1'b0;
        end else if (o_tx_reset) begin
            brk_st <= BRK_IDLE;
            brk_cnt <= 4'h0;
            brk_stop <= 1'b0;
        end else begin
            case (brk_st)
                BRK_IDLE: begin
                    brk_stop <= 1'b0;
                    brk_cnt <= 4'h0;
                    if (cw[`C_BRK_BEGIN]) begin
                        brk_st <= BRK_WAIT;
                    end
                end
                BRK_WAIT: begin
                    if (i_thr_empty && i_tsr_empty) begin
                        brk_st <= BRK_ON;
                    end
                end
                BRK_ON: begin
                    if (cw[`C_BRK_END]) begin
                        brk_stop <= 1'b1;
                    end
                    if (i_bit_tick && brk_cnt < frame_bits(cfg)) begin
                        brk_cnt <= brk_cnt + 4'h1;
                    end
                    if (brk_stop && brk_cnt >= frame_bits(cfg)) begin
                        brk_st <= BRK_MARK;
                        brk_cnt <= 4'h0;
                    end
                end
                BRK_MARK: begin
                    if (i_bit_tick) begin
                        brk_cnt <= brk_cnt + 4'h1;
                        if (brk_cnt == `BRK_MARK_BITS - 4'h1) begin
                            brk_st <= BRK_IDLE;
                        end
                    end
                end
                default: brk_st <= BRK_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Line routing
    rx_filt_if filt ();

    assign filt.raw = loop == `LP_LOCAL ? i_tx_serial : i_rxd;
    assign filt.tick = i_sample_tick;
    assign filt.en = cfg[`F_FILTER];
    assign o_rx_line = filt.clean;

    rx_maj_filter u_filter (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .f(filt)
    );

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_txd <= 1'b1;
        end else begin
            case (loop)
                `LP_NORMAL: o_txd <= brk_st == BRK_ON ? 1'b0 :
                    brk_st == BRK_MARK ? 1'b1 : i_tx_serial;
                `LP_ECHO: o_txd <= i_rxd;
                `LP_LOCAL: o_txd <= 1'b1;
                default: o_txd <= i_rxd;
            endcase
        end
    end

    // ==========================================================
    // Interrupt mask
    logic [31:0] imr;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            imr <= 32'h0;
        end else if (i_wr && i_addr == `IER_OFF) begin
            imr <= imr | (i_wdata & `IRQ_MASK);
        end else if (i_wr && i_addr == `IDR_OFF) begin
            imr <= imr & ~i_wdata;
        end
    end

    // ==========================================================
    // Read port
    logic [31:0] csr;

    always_comb begin
        csr = 32'h0;
        csr[`S_PAR] = f_par;
        csr[`S_FRAME] = f_frame;
        csr[`S_OVR] = f_ovr;
        csr[`S_BRK] = f_brk;
        csr[`S_TOUT] = f_tout;
        csr[`S_ITER] = f_iter;
        csr[`S_NAK] = f_nak;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                `MODE_OFF: o_rdata <= cfg;
                `IMR_OFF: o_rdata <= imr;
                `CSR_OFF: o_rdata <= csr;
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_cmd(int b);
        i_wr && i_addr == `CMD_OFF && i_wdata[b];
    endsequence

    rx_off_wins_a: assert property (s_cmd(`C_RX_OFF) |=> !o_rx_enable)
        else $error("receiver not disabled");
    tx_on_a: assert property (s_cmd(`C_TX_ON) and !i_wdata[`C_TX_OFF] |=> o_tx_enable)
        else $error("transmitter not enabled");
    rx_reset_a: assert property (s_cmd(`C_RX_RST) ##1 !cw[`C_RX_RST]
        |-> o_rx_reset ##1 !o_rx_reset)
        else $error("receiver reset pulse wrong");
    err_clear_a: assert property (s_cmd(`C_ERR_CLR) and !i_parity_err |=> !f_par)
        else $error("parity flag not cleared");
    brk_wait_a: assert property (brk_st == BRK_WAIT && !i_thr_empty |=> brk_st != BRK_ON)
        else $error("break began too early");
    brk_low_a: assert property (brk_st == BRK_ON && loop == `LP_NORMAL |=> !o_txd)
        else $error("break not driven low");
    brk_ignore_a: assert property (brk_st == BRK_IDLE and s_cmd(`C_BRK_END)
        and !i_wdata[`C_BRK_BEGIN] |=> brk_st == BRK_IDLE)
        else $error("break end acted while idle");
    tout_arm_a: assert property (s_cmd(`C_TO_ARM) and !i_char_rx and !i_timeout_expire
        |=> o_timeout_hold && !f_tout)
        else $error("idle timer not armed");
    addr_bit_a: assert property (thr_wr && addr_pend && multidrop
        |=> o_tx_load && o_tx_addr_bit && !addr_pend)
        else $error("address bit not sent");
    dtr_a: assert property (s_cmd(`C_TR_ASSERT) and !i_wdata[`C_TR_DEASSERT] |=> !o_dtr_n)
        else $error("terminal ready not asserted");
    rts_a: assert property (s_cmd(`C_SR_DEASSERT) |=> o_rts_n)
        else $error("send request not released");
    nak_a: assert property (bad_char && !cfg[`F_NAK_INHIBIT] && !cfg[`F_REPEAT_NAK_DISABLE] |=> o_nak_send)
        else $error("nak not sent");
    iter_a: assert property (bad_char && cfg[`F_REPEAT_NAK_DISABLE] && at_limit |=> f_iter && !o_nak_send)
        else $error("retry limit not flagged");
    sck_a: assert property (cfg[`F_CLKS_LO +: 2] == `CLKS_EXT |=> !o_sck_oe)
        else $error("clock driven from external source");
endmodule

/* File: hw/spc_consts.svh */
// Offsets, field positions, reset values and counts of the serial port control block
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define CMD_OFF 8'h00
`define MODE_OFF 8'h04
`define IER_OFF 8'h08
`define IDR_OFF 8'h0c
`define IMR_OFF 8'h10
`define CSR_OFF 8'h14
`define THR_OFF 8'h1c
// ==========================================================
// Command bits
`define C_RX_RST 2
`define C_TX_RST 3
`define C_RX_ON 4
`define C_RX_OFF 5
`define C_TX_ON 6
`define C_TX_OFF 7
`define C_ERR_CLR 8
`define C_BRK_BEGIN 9
`define C_BRK_END 10
`define C_TO_ARM 11
`define C_ADDR 12
`define C_RETRY_CLR 13
`define C_NAK_CLR 14
`define C_TO_RESTART 15
`define C_TR_ASSERT 16
`define C_TR_DEASSERT 17
`define C_SR_ASSERT 18
`define C_SR_DEASSERT 19
// ==========================================================
// Status bits
`define S_BRK 2
`define S_OVR 5
`define S_FRAME 6
`define S_PAR 7
`define S_TOUT 8
`define S_ITER 10
`define S_NAK 13
// ==========================================================
// Line configuration fields
`define F_MODE_LO 0
`define F_CLKS_LO 4
`define F_CHAR_LENGTH_LO 6
`define F_SYNC 8
`define F_PAR_LO 9
`define F_STOP_LO 12
`define F_LOOP_LO 14
`define F_BIT_ORDER_SELECT 16
`define F_NINE 17
`define F_SERIAL_CLOCK_DRIVE 18
`define F_OVER 19
`define F_NAK_INHIBIT 20
`define F_REPEAT_NAK_DISABLE 21
`define F_ITER_LO 24
`define F_FILTER 28
// ==========================================================
// Masks, resets, codes and counts
`define MODE_MASK 32'h173fffff
`define MODE_RESET 32'h00000000
`define IRQ_MASK 32'h000f3fff
`define MD_ISO_T0 4'h4
`define MD_ISO_T1 4'h6
`define CLKS_EXT 2'h3
`define LP_NORMAL 2'h0
`define LP_ECHO 2'h1
`define LP_LOCAL 2'h2
`define LP_REMOTE 2'h3
`define OVS_16 5'h10
`define OVS_8 5'h08
`define BRK_MARK_BITS 4'hc
`endif

/* File: hw/spc_pkg.sv */
// Types shared by the serial port control block
package spc_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {BRK_IDLE, BRK_WAIT, BRK_ON, BRK_MARK} brk_e;
endpackage
